//--- acso_cycle_serial.sv
// Conversion cycle sequencer and three-wire serial output port of the converter.
`timescale 1ns/1ps
`default_nettype none

module acso_cycle_serial
    import acso_pkg::*;
#(
    parameter int unsigned POR_CYCLES  = POR_CYCLES_DFLT,
    parameter int unsigned CONV_CYCLES = CONV_CYCLES_DFLT,
    parameter int unsigned SCK_HALF    = SCK_HALF_DFLT
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         supply_ok_i,
    input  wire logic         cs_n_i,
    input  wire logic         sck_i,
    output logic              sck_o,
    output logic              sck_oe_n_o,
    output logic              sdo_o,
    output logic              sdo_oe_n_o,
    input  wire acso_result_s conv_res_i,
    output acso_phase_e       conv_phase_o,
    output logic              sleep_o,
    output logic              por_active_o
);

    if (POR_CYCLES < 2 || POR_CYCLES > 65535)
    begin : g_bad_por
        $error("POR_CYCLES must lie in 2..65535.");
    end
    if (CONV_CYCLES < 3 || CONV_CYCLES > 65535)
    begin : g_bad_conv
        $error("CONV_CYCLES must lie in 3..65535.");
    end
    if (SCK_HALF < 1 || SCK_HALF > 255)
    begin : g_bad_sck
        $error("SCK_HALF must lie in 1..255.");
    end

    localparam logic [CNT_W-1:0]      POR_LAST   = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0]      CONV_LAST  = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0]      PH_SAMPLE0 = CNT_W'(CONV_CYCLES / 3);
    localparam logic [CNT_W-1:0]      PH_FS0     = CNT_W'((2 * CONV_CYCLES) / 3);
    localparam logic [7:0]            DIV_LAST   = 8'(SCK_HALF - 1);
    localparam logic [LINK_CNT_W-1:0] WORD_CNT   = LINK_CNT_W'(WORD_BITS);
    localparam logic [LINK_CNT_W-1:0] CNT_MAX    = LINK_CNT_W'(WORD_BITS + PAD_BITS);
    localparam logic [4:0]            TOP_IDX    = 5'(WORD_BITS - 1);

    acso_core_s core_q;
    acso_core_s core_d;
    acso_rise_s rise_q;
    acso_rise_s rise_d;
    acso_fall_s fall_q;
    acso_fall_s fall_d;

    logic [4:0] sync_raw;
    logic [4:0] sync_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       sup_s;
    logic       start_s;
    logic       done_s;

    // Pins and link-domain toggles all reach the core through two flops.
    assign sync_raw = {fall_q.done_tgl, rise_q.start_tgl, supply_ok_i, sck_i, cs_n_i};

    acso_sync2 #(
        .WIDTH (5)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    (sync_raw),
        .sync_o     (sync_s)
    );

    assign cs_n_s  = sync_s[0];
    assign sck_s   = sync_s[1];
    assign sup_s   = sync_s[2];
    assign start_s = sync_s[3];
    assign done_s  = sync_s[4];

    // Gray step keeps the frame tag safe to read from the link side.
    function automatic logic [1:0] gray_next(input logic [1:0] g);
        gray_next = {g[0], ~g[1]};
    endfunction

    always_comb
    begin
        core_d            = core_q;
        core_d.cs_n_prev  = cs_n_s;
        core_d.start_seen = start_s;
        core_d.done_seen  = done_s;

        // The mode is re-read at each chip select fall unless we drive the pin.
        if (core_q.cs_n_prev && !cs_n_s && !(core_q.state == ST_OUT && core_q.int_mode))
        begin
            core_d.int_mode = sck_s;
        end

        unique case (core_q.state)
            ST_POR:
            begin
                core_d.eoc_n = 1'b1;
                if (core_q.cnt == POR_LAST)
                begin
                    core_d.state    = ST_CONV;
                    core_d.cnt      = '0;
                    core_d.phase    = PH_OFFSET_CAL;
                    core_d.frame_id = gray_next(core_q.frame_id);
                    core_d.int_mode = sck_s;
                end
                else
                begin
                    core_d.cnt = core_q.cnt + CNT_W'(1);
                end
            end
            ST_CONV:
            begin
                core_d.cnt = core_q.cnt + CNT_W'(1);
                if (core_q.cnt == PH_SAMPLE0 - CNT_W'(1))
                begin
                    core_d.phase = PH_SAMPLE;
                end
                if (core_q.cnt == PH_FS0 - CNT_W'(1))
                begin
                    core_d.phase = PH_FULLSCALE_CAL;
                end
                if (core_q.cnt == CONV_LAST)
                begin
                    // Result is latched once here and left alone until the next one.
                    core_d.word     = {1'b0, conv_res_i.ch, conv_res_i.sig, conv_res_i.exr,
                                       conv_res_i.code};
                    core_d.eoc_n    = 1'b0;
                    core_d.frame_id = gray_next(core_q.frame_id);
                    core_d.phase    = PH_IDLE;
                    core_d.cnt      = '0;
                    core_d.state    = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (start_s != core_q.start_seen)
                begin
                    core_d.state = ST_OUT;
                end
                else if (core_q.int_mode && !cs_n_s)
                begin
                    core_d.state = ST_OUT;
                end
            end
            ST_OUT:
            begin
                if (cs_n_s || (done_s != core_q.done_seen))
                begin
                    core_d.state    = ST_CONV;
                    core_d.cnt      = '0;
                    core_d.eoc_n    = 1'b1;
                    core_d.phase    = PH_OFFSET_CAL;
                    core_d.frame_id = gray_next(core_q.frame_id);
                end
            end
        endcase

        // Internal clock: idles low, then 24 pulses made by dividing the core clock.
        if (core_q.state == ST_OUT && core_q.int_mode && core_d.state == ST_OUT)
        begin
            if (core_q.sck_div == DIV_LAST)
            begin
                core_d.sck_div = '0;
                if (core_q.sck_pulses != WORD_CNT)
                begin
                    core_d.sck = ~core_q.sck;
                    if (core_q.sck)
                    begin
                        core_d.sck_pulses = core_q.sck_pulses + LINK_CNT_W'(1);
                    end
                end
            end
            else
            begin
                core_d.sck_div = core_q.sck_div + 8'h01;
            end
        end
        else
        begin
            core_d.sck        = 1'b0;
            core_d.sck_div    = '0;
            core_d.sck_pulses = '0;
        end

        // A failing supply forces the power-on reset and restarts its timer.
        if (!sup_s)
        begin
            core_d.state = ST_POR;
            core_d.cnt   = '0;
            core_d.phase = PH_IDLE;
            core_d.eoc_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            core_q          <= '0;
            core_q.state    <= ST_POR;
            core_q.phase    <= PH_IDLE;
            core_q.word     <= WORD_RST;
            core_q.eoc_n    <= 1'b1;
            core_q.frame_id <= FRAME_ID_RST;
            core_q.cs_n_prev <= 1'b1;
        end
        else
        begin
            core_q <= core_d;
        end
    end

    // Link side. The word, frame tag and end-of-conversion flag are held still by
    // the core until the word has been shifted out, so they are read here without resampling.
    // Chip select is qualified directly because the host holds it steady around edges.
    always_comb
    begin
        rise_d = rise_q;
        if (!cs_n_i && !core_q.eoc_n)
        begin
            if (rise_q.tok != core_q.frame_id)
            begin
                rise_d.tok       = core_q.frame_id;
                rise_d.cnt       = LINK_CNT_W'(1);
                rise_d.start_tgl = ~rise_q.start_tgl;
            end
            else if (rise_q.cnt != CNT_MAX)
            begin
                rise_d.cnt = rise_q.cnt + LINK_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sck_i)
    begin
        if (!resetn_i)
        begin
            rise_q     <= '0;
            rise_q.tok <= FRAME_ID_RST;
        end
        else
        begin
            rise_q <= rise_d;
        end
    end

    always_comb
    begin
        fall_d = fall_q;
        if (!cs_n_i)
        begin
            fall_d.tok = rise_q.tok;
            fall_d.cnt = rise_q.cnt;
            if (rise_q.cnt < WORD_CNT)
            begin
                fall_d.bit_out = core_q.word[TOP_IDX - rise_q.cnt[4:0]];
            end
            else
            begin
                fall_d.bit_out = 1'b1;
            end
            if (rise_q.cnt == WORD_CNT && fall_q.cnt != WORD_CNT)
            begin
                fall_d.done_tgl = ~fall_q.done_tgl;
            end
        end
    end

    always_ff @(negedge sck_i)
    begin
        if (!resetn_i)
        begin
            fall_q     <= '0;
            fall_q.tok <= FRAME_ID_RST;
        end
        else
        begin
            fall_q <= fall_d;
        end
    end

    // Before the first falling edge of a frame the live end-of-conversion flag shows.
    assign sdo_o        = (fall_q.tok == core_q.frame_id) ? fall_q.bit_out : core_q.eoc_n;
    assign sdo_oe_n_o   = cs_n_s;
    assign sck_o        = core_q.sck;
    assign sck_oe_n_o   = !(core_q.state == ST_OUT && core_q.int_mode);
    assign conv_phase_o = core_q.phase;
    assign sleep_o      = (core_q.state == ST_SLEEP) && cs_n_s;
    assign por_active_o = (core_q.state == ST_POR);

endmodule // acso_cycle_serial

`default_nettype wire

//--- acso_pkg.sv
// Shared constants, state types and carriers for the converter cycle and serial output port.
`default_nettype none

package acso_pkg;

    // Output word layout.
    localparam int unsigned WORD_BITS   = 24;
    localparam int unsigned RES_BITS    = 20;
    localparam int unsigned PAD_BITS    = 8;
    localparam int unsigned STATUS_BITS = 4;
    localparam int unsigned BIT_EOC     = 23;
    localparam int unsigned BIT_CH      = 22;
    localparam int unsigned BIT_SIG     = 21;
    localparam int unsigned BIT_EXR     = 20;
    localparam int unsigned LINK_CNT_W  = 6;
    localparam int unsigned CNT_W       = 16;

    // Timing, in nanoseconds and in core clock cycles.
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned POR_TIME_NS      = 500000;
    localparam int unsigned POR_CYCLES_DFLT  = POR_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned CONV_CYCLES_DFLT = 300;
    localparam int unsigned SCK_HALF_DFLT    = 2;

    // Reset values.
    localparam logic [1:0]           FRAME_ID_RST = 2'h0;
    localparam logic [WORD_BITS-1:0] WORD_RST     = 24'hFFFFFF;

    typedef enum logic [1:0] {
        ST_POR,
        ST_CONV,
        ST_SLEEP,
        ST_OUT
    } acso_state_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_OFFSET_CAL,
        PH_SAMPLE,
        PH_FULLSCALE_CAL
    } acso_phase_e;

    typedef struct packed {
        logic                ch;
        logic                sig;
        logic                exr;
        logic [RES_BITS-1:0] code;
    } acso_result_s;

    typedef struct packed {
        acso_state_e          state;
        acso_phase_e          phase;
        logic [CNT_W-1:0]     cnt;
        logic [WORD_BITS-1:0] word;
        logic                 eoc_n;
        logic [1:0]           frame_id;
        logic                 int_mode;
        logic                 cs_n_prev;
        logic                 start_seen;
        logic                 done_seen;
        logic                 sck;
        logic [7:0]           sck_div;
        logic [LINK_CNT_W-1:0] sck_pulses;
    } acso_core_s;

    typedef struct packed {
        logic [1:0]            tok;
        logic [LINK_CNT_W-1:0] cnt;
        logic                  start_tgl;
    } acso_rise_s;

    typedef struct packed {
        logic [1:0]            tok;
        logic [LINK_CNT_W-1:0] cnt;
        logic                  bit_out;
        logic                  done_tgl;
    } acso_fall_s;

endpackage

`default_nettype wire

//--- acso_sync2.sv
// Two flip-flop level synchroniser for a bundle of single-bit signals.
`timescale 1ns/1ps
`default_nettype none

module acso_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // acso_sync2

`default_nettype wire

//--- acso_assertions.sv
// Checker for the converter cycle and serial output port, watching its ports only.
`timescale 1ns/1ps
`default_nettype none

module acso_assertions
    import acso_pkg::*;
#(
    parameter int unsigned POR_CYCLES = 20
) (
    input wire logic         core_clk_i,
    input wire logic         resetn_i,
    input wire logic         supply_ok_i,
    input wire logic         cs_n_i,
    input wire logic         sck_i,
    input wire logic         sck_o,
    input wire logic         sck_oe_n_o,
    input wire logic         sdo_o,
    input wire logic         sdo_oe_n_o,
    input wire acso_result_s conv_res_i,
    input wire acso_phase_e  conv_phase_o,
    input wire logic         sleep_o,
    input wire logic         por_active_o
);
    logic [15:0] por_cnt_q;
    logic [5:0]  fall_cnt_q;

    // Counts raw supply-good cycles, so the bound below allows for the synchroniser lag.
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i || !por_active_o || !supply_ok_i)
            por_cnt_q <= 16'h0000;
        else
            por_cnt_q <= por_cnt_q + 16'h0001;
    end

    always_ff @(negedge sck_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            fall_cnt_q <= 6'h00;
        else if (fall_cnt_q != 6'h3F)
            fall_cnt_q <= fall_cnt_q + 6'h01;
    end

    chk_sdo_hiz: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cs_n_i [*4] |-> sdo_oe_n_o) else $error("sdo driven with chip select high");
    chk_sleep_cs_high: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !sdo_oe_n_o && $past(!sdo_oe_n_o) |-> !sleep_o) else $error("sleep with chip select low");
    chk_por_on_supply: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        !supply_ok_i |-> ##[1:4] por_active_o) else $error("no reset on low supply");
    chk_por_length: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $fell(por_active_o) |-> $past(por_cnt_q) >= POR_CYCLES && $past(por_cnt_q) <= POR_CYCLES + 4)
        else $error("power-on reset length wrong");
    chk_conv_after_por: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $fell(por_active_o) |-> ##[0:2] conv_phase_o == PH_OFFSET_CAL) else $error("no conversion after reset");
    chk_cal_order: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        conv_phase_o == PH_SAMPLE && $past(conv_phase_o) != PH_SAMPLE |-> $past(conv_phase_o) == PH_OFFSET_CAL)
        else $error("sampling not after offset calibration");
    chk_conv_no_sleep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        conv_phase_o != PH_IDLE |-> !sleep_o) else $error("sleep during conversion");
    chk_eoc_busy: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        conv_phase_o != PH_IDLE && !sdo_oe_n_o |-> sdo_o) else $error("status low during conversion");
    chk_pad_ones: assert property (@(posedge sck_i) disable iff (!resetn_i || cs_n_i)
        fall_cnt_q >= 6'd24 |-> sdo_o) else $error("pad bit not high");
endmodule // acso_assertions

`default_nettype wire

//--- acso_host_model.sv
// Host model that selects the converter and clocks its serial word out.
`timescale 1ns/1ps
`default_nettype none

module acso_host_model (
    input  wire logic core_clk_i,
    input  wire logic sdo_i,
    output var logic  cs_n_o,
    output var logic  sck_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
    end

    // The clock stands low outside frames, which also keeps the external clock mode.
    task automatic read_frame(input int pulses, input int abort_at, output logic [31:0] data);
        data = 32'h0;
        @(posedge core_clk_i);
        #2 cs_n_o = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #11;
        for (int i = 0; i < pulses && i != abort_at; i++)
        begin
            data = {data[30:0], sdo_i};
            sck_o = 1'b1;
            #24 sck_o = 1'b0;
            #24;
        end
        cs_n_o = 1'b1;
    endtask

    task automatic peek(output logic eoc);
        @(posedge core_clk_i);
        #2 cs_n_o = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #2 eoc = sdo_i;
        cs_n_o = 1'b1;
    endtask
endmodule // acso_host_model

`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the converter cycle and serial output port.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import acso_pkg::*;
;
    localparam int unsigned POR_N  = 20;
    localparam int unsigned CONV_N = 12;
    logic         core_clk;
    logic         resetn;
    logic         supply_ok;
    logic         cs_n;
    logic         host_sck;
    logic         sck_pin;
    logic         sck_o;
    logic         sck_oe_n;
    logic         sdo;
    logic         sdo_oe_n;
    logic         sleep;
    logic         por_active;
    acso_result_s conv_res;
    acso_phase_e  phase;
    int           errors;
    int           samples_checked;

    // The pin carries the device clock only while the device drives it.
    assign sck_pin = sck_oe_n ? host_sck : sck_o;

    acso_cycle_serial #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N), .SCK_HALF(2)) DUT (
        .core_clk_i(core_clk), .resetn_i(resetn), .supply_ok_i(supply_ok), .cs_n_i(cs_n),
        .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
        .conv_res_i(conv_res), .conv_phase_o(phase), .sleep_o(sleep), .por_active_o(por_active));

    acso_host_model u_host (.core_clk_i(core_clk), .sdo_i(sdo), .cs_n_o(cs_n), .sck_o(host_sck));

    function automatic logic [23:0] exp_word(input logic [22:0] r);
        return {1'b0, r};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_until(input bit slp, input int limit);
        for (int i = 0; i < limit; i++)
        begin
            @(posedge core_clk);
            #2;
            if (slp ? sleep === 1'b1 : phase !== PH_IDLE)
                break;
        end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        #1_000_000;
        errors++;
        conclude();
    end

    initial
    begin
        logic [22:0] cur;
        logic [22:0] nxt;
        logic [31:0] got;
        logic        eoc;
        logic [23:0] ew;
        errors = 0;
        samples_checked = 0;
        resetn = 1'b0;
        supply_ok = 1'b1;
        cur = 23'h7FFFFF;
        conv_res = acso_result_s'(cur);
        void'($urandom(32'hA61DADC5));
        repeat (12) @(posedge core_clk);
        #2 resetn = 1'b1;
        check("por_active", {31'h0, por_active}, 32'h1);
        for (int k = 0; k < 7; k++)
        begin
            if (k == 4)
            begin
                supply_ok = 1'b0;
                repeat (4) @(posedge core_clk);
                #2 check("por_active", {31'h0, por_active}, 32'h1);
                supply_ok = 1'b1;
            end
            wait_until(1'b1, 300);
            check("sleep", {31'h0, sleep}, 32'h1);
            check("phase", {30'h0, phase}, {30'h0, PH_IDLE});
            check("sdo_oe_n", {31'h0, sdo_oe_n}, 32'h1);
            check("sck_oe_n", {31'h0, sck_oe_n}, 32'h1);
            nxt = (k == 3) ? 23'h000000 : 23'($urandom);
            conv_res = acso_result_s'(nxt);
            u_host.read_frame((k == 1) ? 32 : 24, (k == 2) ? 10 : 99, got);
            ew = exp_word(cur);
            if (k == 2)
                check("abort", {22'h0, got[9:0]}, {22'h0, ew[23:14]});
            else if (k == 1)
                check("word32", got, {ew, 8'hFF});
            else
                check("word", got, {8'h00, ew});
            wait_until(1'b0, 8);
            check("restart", {30'h0, phase}, {30'h0, PH_OFFSET_CAL});
            if (k == 5)
            begin
                u_host.peek(eoc);
                check("eoc", {31'h0, eoc}, 32'h1);
            end
            cur = nxt;
        end
        conclude();
    end
endmodule // tb_top

bind acso_cycle_serial acso_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .supply_ok_i(supply_ok_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .conv_res_i(conv_res_i), .conv_phase_o(conv_phase_o), .sleep_o(sleep_o), .por_active_o(por_active_o));

`default_nettype wire
